/* File: src/sbg_pkg.sv */
`default_nettype none

package sbg_pkg;

	// Rate select register layout
	localparam int unsigned PRE_HI    = 7;
	localparam int unsigned PRE_LO    = 6;
	localparam int unsigned TX_HI     = 5;
	localparam int unsigned TX_LO     = 3;
	localparam int unsigned RX_HI     = 2;
	localparam int unsigned RX_LO     = 0;
	localparam logic [7:0]  SEL_RESET = 8'h00;

	// Counter widths
	localparam int unsigned PRE_W = 4;
	localparam int unsigned RAT_W = 7;
	localparam int unsigned OVS_W = 4;

	// Prescale select codes
	localparam logic [1:0] PRE_CODE_1  = 2'h0;
	localparam logic [1:0] PRE_CODE_3  = 2'h1;
	localparam logic [1:0] PRE_CODE_4  = 2'h2;
	localparam logic [1:0] PRE_CODE_13 = 2'h3;

	// Terminal counts, ratio minus one
	localparam logic [3:0] PRE_MAX_1  = 4'h0;
	localparam logic [3:0] PRE_MAX_3  = 4'h2;
	localparam logic [3:0] PRE_MAX_4  = 4'h3;
	localparam logic [3:0] PRE_MAX_13 = 4'hC;

	// Oversampling factor sixteen, minus one
	localparam logic [3:0] OVS_MAX = 4'hF;

	// Buffer depth marks
	localparam logic [1:0] BUF_EMPTY = 2'h0;
	localparam logic [1:0] BUF_ONE   = 2'h1;
	localparam logic [1:0] BUF_FULL  = 2'h2;

	// Generator states, one-hot
	typedef enum logic [2:0] {
		GEN_OFF  = 3'b001,
		GEN_RUN  = 3'b010,
		GEN_STOP = 3'b100
	} sbg_state_e;

endpackage

`default_nettype wire

/* File: src/sbg_div_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface sbg_div_if #(parameter int unsigned W = 4);
	logic         tick_en;
	logic         clr;
	logic [W-1:0] max;
	logic         tick;

	modport ctl (output tick_en, output clr, output max, input tick);
	modport cnt (input tick_en, input clr, input max, output tick);
endinterface

`default_nettype wire

/* File: src/sbg_div.sv */
`timescale 1ns/1ns
`default_nettype none

module sbg_div #(
	parameter int unsigned W = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	sbg_div_if.cnt   dv
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         at_max;

	// Terminal count reached; >= guards a shrunken max
	assign at_max  = (cnt_q >= dv.max);
	assign dv.tick = dv.tick_en && !dv.clr && at_max;

	// Next count: clear wins, else advance on each input tick
	always_comb begin
		cnt_d = cnt_q;
		if (dv.clr) begin
			cnt_d = '0;
		end else if (dv.tick_en) begin
			if (at_max) begin
				cnt_d = '0;
			end else begin
				cnt_d = W'(cnt_q + 1'b1);
			end
		end
	end

	// Count register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

`default_nettype wire

/* File: src/sbg_top.sv */
`timescale 1ns/1ns
`default_nettype none

module sbg_top (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] sel_wr_data,
	input  wire logic       sel_wr_valid,
	output logic            sel_wr_ready,
	output logic [7:0]      rate_sel,
	input  wire logic       tx_enable,
	input  wire logic       rx_enable,
	input  wire logic       tx_busy,
	input  wire logic       rx_busy,
	input  wire logic       stop_enter,
	input  wire logic       stop_exit_irq,
	input  wire logic       wait_mode,
	input  wire logic       serial_interface_irq,
	output logic            tx_ovs_tick,
	output logic            tx_bit_tick,
	output logic            rx_sample_tick,
	output logic            rx_bit_tick,
	output logic            tx_hold,
	output logic            rx_discard,
	output logic            gen_running,
	output logic            wake_req
);

	sbg_pkg::sbg_state_e state_q;
	sbg_pkg::sbg_state_e state_d;

	logic [7:0] buf_q [2];
	logic [7:0] buf_d [2];
	logic [1:0] fill_q;
	logic [1:0] fill_d;
	logic       ready_q;
	logic       ready_d;
	logic [7:0] sel_q;
	logic [7:0] sel_d;
	logic       push;
	logic       pop;
	logic       any_en;
	logic       run;
	logic       div_clr;

	logic       tx_ovs_q;
	logic       tx_bit_q;
	logic       rx_smp_q;
	logic       rx_bit_q;
	logic       hold_q;
	logic       disc_q;
	logic       disc_d;
	logic       wake_q;
	logic       wake_d;
	logic       run_q;

	sbg_div_if #(.W(sbg_pkg::PRE_W)) pre_if ();
	sbg_div_if #(.W(sbg_pkg::RAT_W)) txr_if ();
	sbg_div_if #(.W(sbg_pkg::RAT_W)) rxr_if ();
	sbg_div_if #(.W(sbg_pkg::OVS_W)) txo_if ();
	sbg_div_if #(.W(sbg_pkg::OVS_W)) rxo_if ();

	// Terminal count for a power-of-two ratio code
	function automatic logic [6:0] ratio_max(input logic [2:0] code);
		ratio_max = 7'((8'h01 << code) - 8'h01);
	endfunction

	// Terminal count for the prescale select
	function automatic logic [3:0] pre_max(input logic [1:0] code);
		case (code)
			sbg_pkg::PRE_CODE_1:  pre_max = sbg_pkg::PRE_MAX_1;
			sbg_pkg::PRE_CODE_3:  pre_max = sbg_pkg::PRE_MAX_3;
			sbg_pkg::PRE_CODE_4:  pre_max = sbg_pkg::PRE_MAX_4;
			sbg_pkg::PRE_CODE_13: pre_max = sbg_pkg::PRE_MAX_13;
			default:              pre_max = sbg_pkg::PRE_MAX_1;
		endcase
	endfunction

	// Enable and transfer conditions
	assign any_en = tx_enable || rx_enable;
	assign push   = sel_wr_valid && ready_q;
	// A new selection is not applied while halted, so the buffer fills
	assign pop    = (fill_q != sbg_pkg::BUF_EMPTY) &&
	                (state_q != sbg_pkg::GEN_STOP);
	// Counting only in run; wait mode has no say here
	assign run     = (state_q == sbg_pkg::GEN_RUN);
	assign div_clr = (state_q == sbg_pkg::GEN_OFF) || pop;

	// Prescaler counts every processor clock while running
	assign pre_if.tick_en = run;
	assign pre_if.clr     = div_clr;
	assign pre_if.max     = pre_max(sel_q[sbg_pkg::PRE_HI:sbg_pkg::PRE_LO]);

	// Rate dividers share the prescaler tick
	assign txr_if.tick_en = pre_if.tick;
	assign txr_if.clr     = div_clr;
	assign txr_if.max     = ratio_max(sel_q[sbg_pkg::TX_HI:sbg_pkg::TX_LO]);
	assign rxr_if.tick_en = pre_if.tick;
	assign rxr_if.clr     = div_clr;
	assign rxr_if.max     = ratio_max(sel_q[sbg_pkg::RX_HI:sbg_pkg::RX_LO]);

	// Divide the sixteen-times ticks down to bit rate
	assign txo_if.tick_en = txr_if.tick;
	assign txo_if.clr     = div_clr;
	assign txo_if.max     = sbg_pkg::OVS_MAX;
	assign rxo_if.tick_en = rxr_if.tick;
	assign rxo_if.clr     = div_clr;
	assign rxo_if.max     = sbg_pkg::OVS_MAX;

	sbg_div #(.W(sbg_pkg::PRE_W)) u_pre (
		.clk   (clk),
		.rst_n (rst_n),
		.dv    (pre_if)
	);

	sbg_div #(.W(sbg_pkg::RAT_W)) u_txr (
		.clk   (clk),
		.rst_n (rst_n),
		.dv    (txr_if)
	);

	sbg_div #(.W(sbg_pkg::RAT_W)) u_rxr (
		.clk   (clk),
		.rst_n (rst_n),
		.dv    (rxr_if)
	);

	sbg_div #(.W(sbg_pkg::OVS_W)) u_txo (
		.clk   (clk),
		.rst_n (rst_n),
		.dv    (txo_if)
	);

	sbg_div #(.W(sbg_pkg::OVS_W)) u_rxo (
		.clk   (clk),
		.rst_n (rst_n),
		.dv    (rxo_if)
	);

	// Generator mode: off, running or halted by stop
	always_comb begin
		state_d = state_q;
		case (state_q)
			sbg_pkg::GEN_OFF: begin
				if (stop_enter) begin
					state_d = sbg_pkg::GEN_STOP;
				end else if (any_en) begin
					state_d = sbg_pkg::GEN_RUN;
				end
			end
			sbg_pkg::GEN_RUN: begin
				if (stop_enter) begin
					state_d = sbg_pkg::GEN_STOP;
				end else if (!any_en) begin
					state_d = sbg_pkg::GEN_OFF;
				end
			end
			sbg_pkg::GEN_STOP: begin
				// Counters keep their values, so a held transfer resumes
				if (stop_exit_irq) begin
					state_d = any_en ? sbg_pkg::GEN_RUN : sbg_pkg::GEN_OFF;
				end
			end
			default: state_d = sbg_pkg::GEN_OFF;
		endcase
	end

	// Two-entry selection buffer; entry 0 is the head
	always_comb begin
		buf_d[0] = buf_q[0];
		buf_d[1] = buf_q[1];
		fill_d   = fill_q;
		sel_d    = sel_q;
		if (pop) begin
			sel_d = buf_q[0];
		end
		case ({push, pop})
			2'b10: begin
				buf_d[fill_q[0]] = sel_wr_data;
				fill_d = 2'(fill_q + 2'h1);
			end
			2'b01: begin
				buf_d[0] = buf_q[1];
				fill_d = 2'(fill_q - 2'h1);
			end
			2'b11: begin
				if (fill_q == sbg_pkg::BUF_ONE) begin
					buf_d[0] = sel_wr_data;
				end else begin
					buf_d[0] = buf_q[1];
					buf_d[1] = sel_wr_data;
				end
			end
			default: fill_d = fill_q;
		endcase
		ready_d = (fill_d != sbg_pkg::BUF_FULL);
	end

	// Stop side effects and wake request
	always_comb begin
		// Partial character is dropped when stop cuts it off
		disc_d = stop_enter && run && rx_busy;
		// Interrupt input is already qualified by enable
		wake_d = wait_mode && serial_interface_irq;
	end

	// Register all state and outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= sbg_pkg::GEN_OFF;
			buf_q[0] <= sbg_pkg::SEL_RESET;
			buf_q[1] <= sbg_pkg::SEL_RESET;
			fill_q   <= sbg_pkg::BUF_EMPTY;
			ready_q  <= 1'b1;
			sel_q    <= sbg_pkg::SEL_RESET;
			tx_ovs_q <= 1'b0;
			tx_bit_q <= 1'b0;
			rx_smp_q <= 1'b0;
			rx_bit_q <= 1'b0;
			hold_q   <= 1'b0;
			disc_q   <= 1'b0;
			wake_q   <= 1'b0;
			run_q    <= 1'b0;
		end else begin
			state_q  <= state_d;
			buf_q    <= buf_d;
			fill_q   <= fill_d;
			ready_q  <= ready_d;
			sel_q    <= sel_d;
			tx_ovs_q <= txr_if.tick;
			tx_bit_q <= txo_if.tick;
			rx_smp_q <= rxr_if.tick;
			rx_bit_q <= rxo_if.tick;
			hold_q   <= (state_d == sbg_pkg::GEN_STOP) && tx_busy;
			disc_q   <= disc_d;
			wake_q   <= wake_d;
			run_q    <= (state_d == sbg_pkg::GEN_RUN);
		end
	end

	// Outputs straight from flops
	assign sel_wr_ready   = ready_q;
	assign rate_sel       = sel_q;
	assign tx_ovs_tick    = tx_ovs_q;
	assign tx_bit_tick    = tx_bit_q;
	assign rx_sample_tick = rx_smp_q;
	assign rx_bit_tick    = rx_bit_q;
	assign tx_hold        = hold_q;
	assign rx_discard     = disc_q;
	assign gen_running    = run_q;
	assign wake_req       = wake_q;

endmodule

`default_nettype wire

/* File: sim/sbg_top_assertions.sv */
`timescale 1ns/1ns
`default_nettype none

module sbg_chk (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] rate_sel,
	input wire logic       tx_enable,
	input wire logic       rx_enable,
	input wire logic       rx_busy,
	input wire logic       stop_enter,
	input wire logic       wait_mode,
	input wire logic       serial_interface_irq,
	input wire logic       tx_ovs_tick,
	input wire logic       rx_sample_tick,
	input wire logic       rx_discard,
	input wire logic       gen_running,
	input wire logic       wake_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Mode and tick relations at the ports
	wake_on_irq_a: assert property (
		wait_mode && serial_interface_irq |=> wake_req) else $error("no wake");
	stop_halts_a: assert property (
		stop_enter && gen_running |=> !gen_running) else $error("not halted");
	frozen_ticks_a: assert property (
		!gen_running && !$past(gen_running) && !$past(gen_running, 2)
		|-> !tx_ovs_tick && !rx_sample_tick) else $error("tick while halted");
	rx_discard_a: assert property (
		stop_enter && gen_running && rx_busy |=> rx_discard)
		else $error("no discard");
	full_rate_a: assert property (
		(gen_running && rate_sel == 8'h00)[*3] |-> rx_sample_tick && tx_ovs_tick)
		else $error("missing tick");
	prescale_gap_a: assert property (
		rx_sample_tick && rate_sel == 8'hC0
		|=> (!rx_sample_tick || rate_sel != 8'hC0)[*8])
		else $error("prescale too fast");
	wait_runs_a: assert property (
		gen_running && wait_mode && !stop_enter && (tx_enable || rx_enable)
		|=> gen_running) else $error("stopped in wait");
	disable_off_a: assert property (
		gen_running && !tx_enable && !rx_enable && !stop_enter
		|=> !gen_running) else $error("not disabled");
endmodule

bind sbg_top sbg_chk u_chk (.clk(clk), .rst_n(rst_n), .rate_sel(rate_sel),
	.tx_enable(tx_enable), .rx_enable(rx_enable), .rx_busy(rx_busy),
	.stop_enter(stop_enter), .wait_mode(wait_mode),
	.serial_interface_irq(serial_interface_irq), .tx_ovs_tick(tx_ovs_tick),
	.rx_sample_tick(rx_sample_tick), .rx_discard(rx_discard),
	.gen_running(gen_running), .wake_req(wake_req));

`default_nettype wire

/* File: sim/sbg_remote.sv */
`timescale 1ns/1ns
`default_nettype none

module sbg_remote (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic bit_tick,
	output logic     busy
);
	logic [3:0] cnt_q;

	// Remote sender: ten-bit frame paced by the receive bit tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) cnt_q <= 4'h0;
		else if (start) cnt_q <= 4'hA;
		else if (bit_tick && cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
	end
	assign busy = (cnt_q != 4'h0);
endmodule

`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench;
	logic clk = 0, rst_n = 0, wv, te, re, txb, se, sx, wm, irq, fs, rb;
	logic [7:0] wd, rs;
	logic rdy, tot, tbt, rst_t, rbt, th, rd, gr, wk;
	integer err_count = 0, comparisons = 0, seed = 32'h0b33_b2f2;
	integer p, t, r, n, k;
	int np[4] = '{1, 3, 4, 13};

	always #2 clk = ~clk;

	sbg_top DUT (.clk(clk), .rst_n(rst_n), .sel_wr_data(wd),
		.sel_wr_valid(wv), .sel_wr_ready(rdy), .rate_sel(rs),
		.tx_enable(te), .rx_enable(re), .tx_busy(txb), .rx_busy(rb),
		.stop_enter(se), .stop_exit_irq(sx), .wait_mode(wm),
		.serial_interface_irq(irq), .tx_ovs_tick(tot), .tx_bit_tick(tbt),
		.rx_sample_tick(rst_t), .rx_bit_tick(rbt), .tx_hold(th),
		.rx_discard(rd), .gen_running(gr), .wake_req(wk));
	sbg_remote u_rem (.clk(clk), .rst_n(rst_n), .start(fs),
		.bit_tick(rbt), .busy(rb));

	// Compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task conclude;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Offer a byte, hold it until an edge that sees ready, then idle one edge
	task wr(input logic [7:0] d);
		wv = 1;
		wd = d;
		for (k = 0; k < 500 && !rdy; k++) @(negedge clk);
		@(negedge clk);
		wv = 0;
		@(negedge clk);
	endtask

	function logic pick(input int w);
		return (w == 0) ? rbt : (w == 1) ? tbt : rst_t;
	endfunction

	// Expected tick period in clocks: ovs times prescale times two to code
	function int per(input int pc, input int code, input int ovs);
		return (ovs * np[pc]) << code;
	endfunction

	// Cycles between two successive ticks of one kind
	task meas(input int w, output int c);
		c = 0;
		while (!pick(w) && c < 40000) begin @(negedge clk); c++; end
		c = 0;
		do begin @(negedge clk); c++; end while (!pick(w) && c < 40000);
	endtask

	// Stimulus
	initial begin
		{wd, wv, te, re, txb, se, sx, wm, irq, fs} = 0;
		repeat (8) @(negedge clk);
		rst_n = 1;
		chk(rs, 8'h00, "rate_sel reset");
		chk(rdy, 1, "ready reset");
		te = 1;
		re = 1;
		for (p = 0; p < 4; p++) begin
			t = $random(seed) & 3;
			r = $random(seed) & 3;
			wr({p[1:0], t[2:0], r[2:0]});
			@(negedge clk);
			chk(rs, {p[1:0], t[2:0], r[2:0]}, "rate_sel");
			meas(2, n);
			chk(n, per(p, r, 1), "sample period");
			meas(0, n);
			chk(n, per(p, r, 16), "rx bit period");
			meas(1, n);
			chk(n, per(p, t, 16), "tx bit period");
		end
		wr(8'h00);
		fs = 1;
		@(negedge clk);
		fs = 0;
		repeat (3) @(negedge clk);
		txb = 1;
		se = 1;
		@(negedge clk);
		se = 0;
		chk(rd, 1, "rx discard");
		chk(gr, 0, "halted");
		repeat (3) @(negedge clk);
		n = 0;
		repeat (40) begin @(negedge clk); n += tot | rst_t; end
		chk(n, 0, "ticks in stop");
		chk(th, 1, "tx hold");
		wr(8'h49);
		wr(8'h52);
		chk(rdy, 0, "ready when full");
		chk(rs, 8'h00, "no apply in stop");
		sx = 1;
		@(negedge clk);
		sx = 0;
		@(negedge clk);
		chk(gr, 1, "resumed");
		repeat (4) @(negedge clk);
		chk(rs, 8'h52, "drained");
		txb = 0;
		wm = 1;
		irq = 1;
		repeat (2) @(negedge clk);
		chk(wk, 1, "wake");
		meas(2, n);
		chk(n, per(1, 2, 1), "wait sample period");
		wm = 0;
		irq = 0;
		// Let both directions go idle, then a clean stop and wake
		for (k = 0; k < 4000 && rb; k++) @(negedge clk);
		chk(rb, 0, "rx idle before stop");
		se = 1;
		@(negedge clk);
		se = 0;
		chk(rd, 0, "no discard when idle");
		chk(th, 0, "no hold when idle");
		chk(gr, 0, "clean stop");
		sx = 1;
		@(negedge clk);
		sx = 0;
		@(negedge clk);
		chk(gr, 1, "clean wake");
		te = 0;
		re = 0;
		repeat (2) @(negedge clk);
		chk(gr, 0, "disabled");
		conclude;
	end

	// Hang guard, well past the longest expected run
	initial begin
		#200_000;
		err_count++;
		conclude;
	end
endmodule

`default_nettype wire
